/* common/sfc_pkg.sv */
`default_nettype none

package sfc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int SFC_NUM_REGS = 17;             // Registers in the bank
    localparam int SFC_ADDR_W = 5;                // Register address width
    localparam int SFC_DATA_W = 8;                // Register data width

    localparam logic [4:0] SFC_IDX_RC_COARSE = 5'h00;    // rc_osc_coarse_cal
    localparam logic [4:0] SFC_IDX_RC_OFFSET = 5'h01;    // rc_osc_clock_offset
    localparam logic [4:0] SFC_IDX_OFF_HIGH = 5'h02;     // carrier_word_offset_high
    localparam logic [4:0] SFC_IDX_OFF_LOW = 5'h03;      // carrier_word_offset_low
    localparam logic [4:0] SFC_IDX_CW_TOP = 5'h04;       // carrier_word_top
    localparam logic [4:0] SFC_IDX_CW_MID = 5'h05;       // carrier_word_mid
    localparam logic [4:0] SFC_IDX_CW_BOTTOM = 5'h06;    // carrier_word_bottom
    localparam logic [4:0] SFC_IDX_IF_TWO = 5'h07;       // if_converter_cfg_two
    localparam logic [4:0] SFC_IDX_IF_ONE = 5'h08;       // if_converter_cfg_one
    localparam logic [4:0] SFC_IDX_IF_ZERO = 5'h09;      // if_converter_cfg_zero
    localparam logic [4:0] SFC_IDX_DIG_ONE = 5'h0a;      // synth_digital_one
    localparam logic [4:0] SFC_IDX_LOOP_BW = 5'h0b;      // synth_loop_bandwidth
    localparam logic [4:0] SFC_IDX_CAL_RES = 5'h0c;      // synth_cal_resolution
    localparam logic [4:0] SFC_IDX_DAC_START = 5'h0d;    // synth_tuning_dac_start
    localparam logic [4:0] SFC_IDX_CAL_RSVD = 5'h0e;     // synth_cal_reserved
    localparam logic [4:0] SFC_IDX_LOCK_CFG = 5'h0f;     // synth_lock_detect_cfg
    localparam logic [4:0] SFC_IDX_PUMP = 5'h10;         // synth_pump_current

    // ------------------------------------------------------------
    // Reset values and writable-bit masks, by register index
    // ------------------------------------------------------------
    localparam logic [7:0] SFC_RESET [SFC_NUM_REGS] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'ha6,
        8'h04, 8'h08, 8'h5a, 8'h00, 8'h20, 8'h00, 8'h00, 8'h28};
    localparam logic [7:0] SFC_WMASK [SFC_NUM_REGS] = '{
        8'h7f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff,
        8'h07, 8'h0f, 8'hff, 8'h1f, 8'h3f, 8'hff, 8'h0f, 8'h3f};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SFC_RX_BW_LSB = 2;             // Receive loop bandwidth [3:2]
    localparam int SFC_TX_BW_LSB = 0;             // Transmit loop bandwidth [1:0]
    localparam int SFC_HIGH_RES_BIT = 4;          // Gain high resolution enable
    localparam int SFC_LOCK_LSB = 2;              // Lock averaging code [3:2]
    localparam int SFC_OFF_SHIFT = 2;             // 2^18 / 2^16 alignment of offset

    // ------------------------------------------------------------
    // Decode tables
    // ------------------------------------------------------------
    // Loop bandwidth in units of 100 Hz for codes 00..11
    localparam logic [10:0] SFC_BW_TABLE [4] = '{11'd1016, 11'd1317, 11'd1500, 11'd1708};
    // Lock detector averaging cycles for codes 00..10; 11 is unbounded
    localparam logic [10:0] SFC_LOCK_TABLE [3] = '{11'd512, 11'd1024, 11'd256};
    localparam logic [1:0] SFC_LOCK_INFINITE = 2'b11;

endpackage

`default_nettype wire

/* design/sfc_field.sv */
`timescale 1ns/1ps
`default_nettype none

// One configuration byte: masked write, fixed reset value
module sfc_field #(
    parameter logic [7:0] RESET_VAL = 8'h00,   // Value after reset
    parameter logic [7:0] WMASK = 8'hff        // Writable bits
) (
    input wire logic core_clk_i,               // Core clock
    input wire logic sys_rst_i,                // Synchronous reset, high
    input wire logic clk_en_i,                 // Clock enable
    input wire logic load_i,                   // Load strobe
    input wire logic [7:0] data_i,             // Load data
    output logic [7:0] value_o                 // Stored byte
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] value;                     // Stored byte
    } sfc_field_state_t;

    sfc_field_state_t state_reg;               // Registered state
    sfc_field_state_t state_next;              // Next state

    // Next state: masked bits never leave zero
    always_comb begin
        state_next = state_reg;
        if (load_i) begin
            state_next.value = data_i & WMASK;
        end
    end

    // Reset wins over the clock enable so a frozen block still resets
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg.value <= RESET_VAL;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    assign value_o = state_reg.value;

endmodule

`default_nettype wire

/* design/sfc_regs.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module sfc_regs
    import sfc_pkg::*;
(
    // ------------------------------------------------------------
    // Clock, reset, enable
    // ------------------------------------------------------------
    input wire logic core_clk_i,                    // Core clock, 125 MHz
    input wire logic sys_rst_i,                     // Synchronous reset, high
    input wire logic clk_en_i,                      // Freezes all state when low

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    input wire logic [SFC_ADDR_W-1:0] reg_addr_i,   // Register index
    input wire logic [SFC_DATA_W-1:0] reg_wdata_i,  // Write data
    input wire logic reg_wr_i,                      // Write strobe
    input wire logic reg_rd_i,                      // Read strobe
    output logic [SFC_DATA_W-1:0] reg_rdata_o,      // Read data, cycle after strobe

    // ------------------------------------------------------------
    // Frequency compensation update
    // ------------------------------------------------------------
    input wire logic auto_compensation_strobe_i,    // Load new offset
    input wire logic [15:0] compensation_offset_i,  // Signed offset to load

    // ------------------------------------------------------------
    // Settings towards the synthesizer and converters
    // ------------------------------------------------------------
    output logic [6:0] rc_coarse_value_o,           // RC oscillator coarse value
    output logic [4:0] rc_clock_offset_test_o,      // RC clock offset, test
    output logic signed [15:0] signed_carrier_offset_o, // Signed frequency offset
    output logic [23:0] carrier_word_o,             // Carrier frequency word
    output logic signed [26:0] vco_word_o,          // VCO word in f_xosc/2^18 units
    output logic [1:0] if_cfg_two_o,                // IF converter test bits
    output logic [7:0] if_cfg_one_o,                // IF converter test bits
    output logic [2:0] if_cfg_zero_o,               // IF converter test bits
    output logic [3:0] synth_digital_one_o,         // Synthesizer test bits
    output logic [3:0] synth_loop_reserved_o,       // Loop register test bits
    output logic [1:0] receive_loop_bandwidth_o,    // Receive bandwidth code
    output logic [1:0] transmit_loop_bandwidth_o,   // Transmit bandwidth code
    output logic [10:0] receive_bw_100hz_o,         // Receive bandwidth, 100 Hz units
    output logic [10:0] transmit_bw_100hz_o,        // Transmit bandwidth, 100 Hz units
    output logic gain_high_resolution_o,            // High-resolution calibration
    output logic [3:0] cal_resolution_reserved_o,   // Calibration test bits
    output logic [5:0] tuning_dac_initial_o,        // Tuning DAC start value
    output logic [7:0] cal_reserved_o,              // Calibration test byte
    output logic [1:0] lock_cfg_reserved_o,         // Lock register test bits
    output logic [10:0] lock_avg_cycles_o,          // Lock averaging length
    output logic lock_avg_infinite_o,               // Unbounded averaging
    output logic [5:0] pump_current_setting_o       // Charge pump setting
);

    // ------------------------------------------------------------
    // Field storage
    // ------------------------------------------------------------
    logic [7:0] reg_val [SFC_NUM_REGS];             // Current byte of each register
    logic reg_load [SFC_NUM_REGS];                  // Load strobe per register
    logic [7:0] reg_load_data [SFC_NUM_REGS];       // Load data per register
    logic addr_mapped;                              // Address hits a register

    // Host writes and compensation updates feed one load per register.
    // The strobe wins a collision on the offset bytes: the measured offset
    // is fresher than a host write landing in the same cycle.
    always_comb begin
        for (int i = 0; i < SFC_NUM_REGS; i++) begin
            reg_load[i] = reg_wr_i && (reg_addr_i == 5'(i));
            reg_load_data[i] = reg_wdata_i;
        end
        if (auto_compensation_strobe_i) begin
            // Both halves load in one cycle, never torn
            reg_load[SFC_IDX_OFF_HIGH] = 1'b1;
            reg_load_data[SFC_IDX_OFF_HIGH] = compensation_offset_i[15:8];
            reg_load[SFC_IDX_OFF_LOW] = 1'b1;
            reg_load_data[SFC_IDX_OFF_LOW] = compensation_offset_i[7:0];
        end
    end

    // One byte cell per register; resets and masks come from the map
    for (genvar g = 0; g < SFC_NUM_REGS; g++) begin : g_field
        sfc_field #(
            .RESET_VAL(SFC_RESET[g]),
            .WMASK(SFC_WMASK[g])
        ) u_field (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .clk_en_i(clk_en_i),
            .load_i(reg_load[g]),
            .data_i(reg_load_data[g]),
            .value_o(reg_val[g])
        );
    end

    assign addr_mapped = (reg_addr_i < 5'(SFC_NUM_REGS));

    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rdata;                          // Read data holding register
        logic signed [26:0] vco_word;               // Combined tuning word
        logic [10:0] rx_bw;                         // Decoded receive bandwidth
        logic [10:0] tx_bw;                         // Decoded transmit bandwidth
        logic [10:0] lock_cycles;                   // Decoded averaging length
        logic lock_inf;                             // Unbounded averaging
    } sfc_regs_state_t;

    sfc_regs_state_t state_reg;                     // Registered state
    sfc_regs_state_t state_next;                    // Next state

    logic [23:0] carrier_word;                      // Assembled carrier word
    logic signed [15:0] offset_word;                // Assembled signed offset
    logic [1:0] rx_code;                            // Receive bandwidth code
    logic [1:0] tx_code;                            // Transmit bandwidth code
    logic [1:0] lock_code;                          // Lock averaging code

    // Word assembly from the byte registers
    assign carrier_word = {reg_val[SFC_IDX_CW_TOP], reg_val[SFC_IDX_CW_MID],
                           reg_val[SFC_IDX_CW_BOTTOM]};
    assign offset_word = {reg_val[SFC_IDX_OFF_HIGH],
                          reg_val[SFC_IDX_OFF_LOW]};
    assign rx_code = reg_val[SFC_IDX_LOOP_BW][SFC_RX_BW_LSB +: 2];
    assign tx_code = reg_val[SFC_IDX_LOOP_BW][SFC_TX_BW_LSB +: 2];
    assign lock_code = reg_val[SFC_IDX_LOCK_CFG][SFC_LOCK_LSB +: 2];

    // Next state: read capture and decoded synthesizer settings
    always_comb begin
        state_next = state_reg;
        // Read data stands only in the cycle after the strobe
        if (reg_rd_i && addr_mapped) begin
            // Masked bits are stored as zero, so they read as zero
            state_next.rdata = reg_val[reg_addr_i];
        end else begin
            state_next.rdata = 8'h00;
        end
        // Carrier word is shifted up two places so that both terms share
        // the 2^18 scale; the offset is sign extended before the sum
        state_next.vco_word = $signed({1'b0, carrier_word, 2'b00})
                              + 27'(offset_word);
        state_next.rx_bw = SFC_BW_TABLE[rx_code];
        state_next.tx_bw = SFC_BW_TABLE[tx_code];
        // Lock averaging: code 11 has no cycle limit
        case (lock_code)
            2'b00, 2'b01, 2'b10: begin
                state_next.lock_cycles = SFC_LOCK_TABLE[lock_code];
                state_next.lock_inf = 1'b0;
            end
            default: begin
                state_next.lock_cycles = 11'h000;
                state_next.lock_inf = (lock_code == SFC_LOCK_INFINITE);
            end
        endcase
    end

    // Register the block state; reset takes constants only
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg.rdata <= 8'h00;
            state_reg.vco_word <= 27'h0000000;
            state_reg.rx_bw <= 11'd1500;
            state_reg.tx_bw <= 11'd1500;
            state_reg.lock_cycles <= 11'd512;
            state_reg.lock_inf <= 1'b0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = state_reg.rdata;
    assign rc_coarse_value_o = reg_val[SFC_IDX_RC_COARSE][6:0];
    // Test-only fields simply keep what the host loaded
    assign rc_clock_offset_test_o = reg_val[SFC_IDX_RC_OFFSET][4:0];
    assign signed_carrier_offset_o = offset_word;
    assign carrier_word_o = carrier_word;
    assign vco_word_o = state_reg.vco_word;
    assign if_cfg_two_o = reg_val[SFC_IDX_IF_TWO][1:0];
    assign if_cfg_one_o = reg_val[SFC_IDX_IF_ONE];
    assign if_cfg_zero_o = reg_val[SFC_IDX_IF_ZERO][2:0];
    assign synth_digital_one_o = reg_val[SFC_IDX_DIG_ONE][3:0];
    assign synth_loop_reserved_o = reg_val[SFC_IDX_LOOP_BW][7:4];
    assign receive_loop_bandwidth_o = rx_code;
    assign transmit_loop_bandwidth_o = tx_code;
    assign receive_bw_100hz_o = state_reg.rx_bw;
    assign transmit_bw_100hz_o = state_reg.tx_bw;
    // Calibration logic lengthens its sequence when this is set
    assign gain_high_resolution_o =
        reg_val[SFC_IDX_CAL_RES][SFC_HIGH_RES_BIT];
    assign cal_resolution_reserved_o = reg_val[SFC_IDX_CAL_RES][3:0];
    assign tuning_dac_initial_o = reg_val[SFC_IDX_DAC_START][5:0];
    assign cal_reserved_o = reg_val[SFC_IDX_CAL_RSVD];
    assign lock_cfg_reserved_o = reg_val[SFC_IDX_LOCK_CFG][1:0];
    assign lock_avg_cycles_o = state_reg.lock_cycles;
    assign lock_avg_infinite_o = state_reg.lock_inf;
    assign pump_current_setting_o = reg_val[SFC_IDX_PUMP][5:0];

endmodule

`default_nettype wire

/* sim/sfc_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checks for the configuration bank
// ----------------------------------------------------------------
module sfc_regs_properties
    import sfc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [SFC_ADDR_W-1:0] reg_addr_i,
    input wire logic [SFC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [SFC_DATA_W-1:0] reg_rdata_o,
    input wire logic auto_compensation_strobe_i,
    input wire logic [15:0] compensation_offset_i,
    input wire logic [6:0] rc_coarse_value_o,
    input wire logic signed [15:0] signed_carrier_offset_o,
    input wire logic [23:0] carrier_word_o,
    input wire logic signed [26:0] vco_word_o,
    input wire logic [1:0] receive_loop_bandwidth_o,
    input wire logic [1:0] transmit_loop_bandwidth_o,
    input wire logic [10:0] receive_bw_100hz_o,
    input wire logic [10:0] transmit_bw_100hz_o,
    input wire logic [10:0] lock_avg_cycles_o,
    input wire logic lock_avg_infinite_o,
    input wire logic [5:0] tuning_dac_initial_o,
    input wire logic [5:0] pump_current_setting_o
);
    // Bandwidth in 100 Hz steps, written out apart from the design's table
    function automatic logic [10:0] bw_of(input logic [1:0] c);
        return c[1] ? (c[0] ? 11'h6ac : 11'h5dc) : (c[0] ? 11'h525 : 11'h3f8);
    endfunction

    // One clock domain, so clocking and disable are given once
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_coarse_write: assert property (reg_wr_i && clk_en_i
        && reg_addr_i == SFC_IDX_RC_COARSE
        |=> rc_coarse_value_o == $past(reg_wdata_i[6:0])) else $error("coarse write lost");
    a_coarse_readback: assert property (reg_rd_i && clk_en_i
        && reg_addr_i == SFC_IDX_RC_COARSE
        |=> reg_rdata_o == {1'b0, $past(rc_coarse_value_o)}) else $error("coarse read wrong");
    a_strobe_loads_offset: assert property (auto_compensation_strobe_i && clk_en_i
        |=> signed_carrier_offset_o == $past(compensation_offset_i))
        else $error("offset not loaded");
    a_offset_low_read: assert property (reg_rd_i && clk_en_i
        && reg_addr_i == SFC_IDX_OFF_LOW
        |=> reg_rdata_o == $past(signed_carrier_offset_o[7:0]))
        else $error("offset low read wrong");
    a_carrier_mid_write: assert property (reg_wr_i && clk_en_i
        && reg_addr_i == SFC_IDX_CW_MID
        |=> carrier_word_o[15:8] == $past(reg_wdata_i) && $stable(carrier_word_o[23:16]))
        else $error("carrier mid write wrong");
    a_vco_word_sum: assert property (clk_en_i |=> vco_word_o == $past($signed({1'b0,
        carrier_word_o, 2'b00}) + 27'(signed_carrier_offset_o))) else $error("vco word wrong");
    a_bw_decode: assert property (clk_en_i |=> receive_bw_100hz_o == bw_of($past(
        receive_loop_bandwidth_o))
        && transmit_bw_100hz_o == bw_of($past(transmit_loop_bandwidth_o)))
        else $error("bandwidth decode wrong");
    a_lock_avg_pair: assert property (lock_avg_infinite_o
        == (lock_avg_cycles_o == 11'h000)
        && lock_avg_cycles_o inside {11'h000, 11'h100, 11'h200, 11'h400}) else $error("lock avg bad");
    a_reset_defaults: assert property ($fell(sys_rst_i) |-> tuning_dac_initial_o == 6'h20
        && pump_current_setting_o == 6'h28) else $error("calibration defaults wrong");

    // Main scenarios reached
    c_strobe: cover property (auto_compensation_strobe_i && clk_en_i);
    c_lock_infinite: cover property (lock_avg_infinite_o);
    c_coarse_read: cover property (reg_rd_i && reg_addr_i == SFC_IDX_RC_COARSE);
endmodule

bind sfc_regs sfc_regs_properties i_sfc_regs_properties (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .auto_compensation_strobe_i(auto_compensation_strobe_i),
    .compensation_offset_i(compensation_offset_i), .rc_coarse_value_o(rc_coarse_value_o),
    .signed_carrier_offset_o(signed_carrier_offset_o), .carrier_word_o(carrier_word_o),
    .vco_word_o(vco_word_o), .receive_loop_bandwidth_o(receive_loop_bandwidth_o),
    .transmit_loop_bandwidth_o(transmit_loop_bandwidth_o),
    .receive_bw_100hz_o(receive_bw_100hz_o), .transmit_bw_100hz_o(transmit_bw_100hz_o),
    .lock_avg_cycles_o(lock_avg_cycles_o), .lock_avg_infinite_o(lock_avg_infinite_o),
    .tuning_dac_initial_o(tuning_dac_initial_o), .pump_current_setting_o(pump_current_setting_o)
);

`default_nettype wire

/* sim/sfc_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the configuration bank
// ----------------------------------------------------------------
`define CHK(nm, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        miscompares++; \
    end \
end

module sfc_regs_tb
    import sfc_pkg::*;
;
    logic core_clk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i, auto_compensation_strobe_i;
    logic [4:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, rdv;
    logic [15:0] compensation_offset_i;
    logic signed [15:0] signed_carrier_offset_o;
    logic [23:0] carrier_word_o;
    logic signed [26:0] vco_word_o;
    logic [1:0] rx_code, tx_code;
    logic [10:0] rx_bw, tx_bw, lock_cycles;
    logic lock_inf, gain_hi;
    logic [5:0] dac_start, pump;
    logic [6:0] coarse;
    logic [4:0] rco;
    logic [1:0] if2, lkr;
    logic [7:0] if1, calr;
    logic [2:0] if0;
    logic [3:0] dig1, lpr, crr;
    logic [46:0] tf; // Plain field outputs side by side, coarse value on top
    assign tf = {coarse, rco, if2, if1, if0, dig1, lpr, crr, calr, lkr};
    logic [10:0] bw_t [4] = '{11'h3f8, 11'h525, 11'h5dc, 11'h6ac}; // 1016 1317 1500 1708
    logic [10:0] lk_t [4] = '{11'h200, 11'h400, 11'h100, 11'h000}; // 512 1024 256 none
    int miscompares = 0;
    int cmp_count = 0;

    sfc_regs i_sfc_regs (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .auto_compensation_strobe_i(auto_compensation_strobe_i),
        .compensation_offset_i(compensation_offset_i), .rc_coarse_value_o(coarse),
        .rc_clock_offset_test_o(rco), .signed_carrier_offset_o(signed_carrier_offset_o),
        .carrier_word_o(carrier_word_o), .vco_word_o(vco_word_o), .if_cfg_two_o(if2),
        .if_cfg_one_o(if1), .if_cfg_zero_o(if0), .synth_digital_one_o(dig1),
        .synth_loop_reserved_o(lpr),
        .receive_loop_bandwidth_o(rx_code), .transmit_loop_bandwidth_o(tx_code),
        .receive_bw_100hz_o(rx_bw), .transmit_bw_100hz_o(tx_bw),
        .gain_high_resolution_o(gain_hi), .cal_resolution_reserved_o(crr),
        .tuning_dac_initial_o(dac_start), .cal_reserved_o(calr), .lock_cfg_reserved_o(lkr),
        .lock_avg_cycles_o(lock_cycles), .lock_avg_infinite_o(lock_inf),
        .pump_current_setting_o(pump)
    );

    // 125 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Bus tasks enter and leave off the edge, so outputs are settled on return
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    // Reset held for 20 cycles
    task automatic do_reset();
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Every index, one past the end included, reads its reset value
    task automatic t_reset();
        for (int i = 0; i <= 17; i++) begin
            rd(5'(i), rdv);
            `CHK("reset value", (i < 17) ? SFC_RESET[i] : 8'h00, rdv)
        end
        `CHK("dac start", 6'h20, dac_start)
        `CHK("pump current", 6'h28, pump)
        // Fields 00 00 2 a6 4 8 5 0 00 0 packed in the order of tf
        `CHK("test fields reset", 47'h54d214000, tf)
        $display("t_reset done");
    endtask

    // All ones written everywhere; unused bits and the unmapped index read zero
    task automatic t_masks();
        for (int i = 0; i <= 17; i++) begin
            wr(5'(i), 8'hff);
            rd(5'(i), rdv);
            `CHK("write mask", (i < 17) ? SFC_WMASK[i] : 8'h00, rdv)
        end
        `CHK("test fields ones", {47{1'b1}}, tf)
        $display("t_masks done");
    endtask

    // Carrier bytes and a negative offset combine into the vco word
    task automatic t_carrier();
        wr(SFC_IDX_CW_TOP, 8'h12);
        wr(SFC_IDX_CW_MID, 8'h34);
        wr(SFC_IDX_CW_BOTTOM, 8'h56);
        wr(SFC_IDX_OFF_HIGH, 8'hff);
        wr(SFC_IDX_OFF_LOW, 8'hfe);
        `CHK("carrier word", 24'h123456, carrier_word_o)
        `CHK("offset", 16'hfffe, signed_carrier_offset_o)
        `CHK("vco word", 27'h048d156, vco_word_o)
        $display("t_carrier done");
    endtask

    // Strobe beside a host write, then reads back to back with no gap
    task automatic t_strobe();
        @(posedge core_clk_i);
        reg_addr_i <= SFC_IDX_OFF_HIGH;
        reg_wdata_i <= 8'h11;
        reg_wr_i <= 1'b1;
        auto_compensation_strobe_i <= 1'b1;
        compensation_offset_i <= 16'h8001;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        auto_compensation_strobe_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_addr_i <= SFC_IDX_OFF_LOW;
        #1;
        `CHK("offset high read", 8'h80, reg_rdata_o)
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK("offset low read", 8'h01, reg_rdata_o)
        `CHK("vco after strobe", 27'h0485159, vco_word_o)
        $display("t_strobe done");
    endtask

    // Every bandwidth and lock code, and the gain resolution bit
    task automatic t_codes();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(SFC_IDX_LOOP_BW, {4'h5, c, 2'h3 - c});
            `CHK("bw codes", {c, 2'h3 - c}, {rx_code, tx_code})
            `CHK("rx bw", bw_t[i], rx_bw)
            `CHK("tx bw", bw_t[3 - i], tx_bw)
            wr(SFC_IDX_LOCK_CFG, {4'h0, c, 2'h1});
            `CHK("lock cycles", lk_t[i], lock_cycles)
            `CHK("lock infinite", (i == 3), lock_inf)
        end
        wr(SFC_IDX_CAL_RES, 8'h10);
        `CHK("gain high res on", 1'b1, gain_hi)
        wr(SFC_IDX_CAL_RES, 8'h0f);
        `CHK("gain high res off", 1'b0, gain_hi)
        $display("t_codes done");
    endtask

    // A write made while the clock enable is low is lost
    task automatic t_freeze();
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(SFC_IDX_CW_TOP, 8'haa);
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        #1;
        `CHK("frozen carrier top", 8'h12, carrier_word_o[23:16])
        $display("t_freeze done");
    endtask

    // Guard against a hang
    initial begin
        repeat (20000) @(posedge core_clk_i);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        sys_rst_i = 1'b1;
        clk_en_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        auto_compensation_strobe_i = 1'b0;
        reg_addr_i = 5'h00;
        reg_wdata_i = 8'h00;
        compensation_offset_i = 16'h0000;
        do_reset();
        t_reset();
        t_masks();
        t_carrier();
        t_strobe();
        t_codes();
        t_freeze();
        do_reset();
        t_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
